// ===== rtl/sfpe_consts.vh
`ifndef SFPE_CONSTS_VH
`define SFPE_CONSTS_VH

// Clock of the sequencer
`define SFPE_CLK_PERIOD_NS 5

// Self-timed cycle lengths in ns
`define SFPE_PAGE_WRITE_TIME_NS 1000000
`define SFPE_BLOCK_WIPE_TIME_NS 100000000
`define SFPE_FULL_WIPE_TIME_NS  200000000

// Same lengths in clock cycles
`define SFPE_PAGE_WRITE_CYC (`SFPE_PAGE_WRITE_TIME_NS / `SFPE_CLK_PERIOD_NS)
`define SFPE_BLOCK_WIPE_CYC (`SFPE_BLOCK_WIPE_TIME_NS / `SFPE_CLK_PERIOD_NS)
`define SFPE_FULL_WIPE_CYC  (`SFPE_FULL_WIPE_TIME_NS / `SFPE_CLK_PERIOD_NS)

// Address layout
`define SFPE_ADDR_W     23
`define SFPE_SECTOR_LSB 16
`define SFPE_PAGE_LSB   8
`define SFPE_PAGE_BYTES 256

// Bit counts, last index of each field
`define SFPE_BYTE_LAST  5'h07
`define SFPE_ADDR_LAST  5'h17
`define SFPE_SIG_DUMMY_LAST 5'h17

// Status byte layout
`define SFPE_SR_BUSY  0
`define SFPE_SR_LATCH 1
`define SFPE_SR_PROT  2
`define SFPE_SR_RESET 8'h00

`endif

// ===== rtl/sfpe_flash_seq.v
`timescale 1ns/10ps
`default_nettype none
`include "sfpe_consts.vh"
module sfpe_flash_seq #(
  parameter [7:0]  P_OP_QUICK_READ  = 8'h0B,
  parameter [7:0]  P_OP_PAGE_WRITE  = 8'h02,
  parameter [7:0]  P_OP_BLOCK_WIPE  = 8'hD8,
  parameter [7:0]  P_OP_FULL_WIPE   = 8'hC7,
  parameter [7:0]  P_OP_WRITE_UNLOCK = 8'h06,
  parameter [7:0]  P_OP_LEGACY_ID   = 8'hAB,
  parameter [7:0]  P_OP_STATUS_READ = 8'h05,
  // Arbitrary signature value
  parameter [7:0]  P_SIGNATURE      = 8'h5A,
  parameter [31:0] P_PAGE_WRITE_CYC = `SFPE_PAGE_WRITE_CYC,
  parameter [31:0] P_BLOCK_WIPE_CYC = `SFPE_BLOCK_WIPE_CYC,
  parameter [31:0] P_FULL_WIPE_CYC  = `SFPE_FULL_WIPE_CYC
) (
  // Clock and reset
  input  wire                    I_CLK,
  input  wire                    I_RESET_N,
  // Serial link
  input  wire                    I_CS_N,
  input  wire                    I_SCK,
  input  wire                    I_SI,
  output wire                    O_SO,
  output wire                    O_SO_OE_N,
  // Status bits
  input  wire [2:0]              I_PROTECT_LEVEL,
  output wire                    O_BUSY,
  output wire                    O_WRITE_LATCH,
  // Memory array port
  output wire [`SFPE_ADDR_W-1:0] O_MEM_ADDR,
  input  wire [7:0]              I_MEM_RDATA,
  output wire                    O_MEM_WR,
  output wire [7:0]              O_MEM_WDATA,
  output wire                    O_MEM_ERASE_SECT,
  output wire                    O_MEM_ERASE_ALL
);

  localparam [5:0] ST_CMD   = 6'h01;
  localparam [5:0] ST_ADDR  = 6'h02;
  localparam [5:0] ST_DUMMY = 6'h04;
  localparam [5:0] ST_OUT   = 6'h08;
  localparam [5:0] ST_PDATA = 6'h10;
  localparam [5:0] ST_SKIP  = 6'h20;

  localparam [1:0] OM_MEM  = 2'h0;
  localparam [1:0] OM_SIG  = 2'h1;
  localparam [1:0] OM_STAT = 2'h2;

  // Protected when sector lies in the top area chosen by the level
  function prot_hit;
    input [2:0] level;
    input [6:0] sector;
    reg   [7:0] span;
    begin
      span = 8'h01 << (level - 3'h1);
      if (level == 3'h0) begin
        prot_hit = 1'b0;
      end else if (level == 3'h7) begin
        prot_hit = 1'b1;
      end else begin
        prot_hit = ({1'b0, sector} >= (8'h80 - span));
      end
    end
  endfunction

  // True on the last bit of a byte
  function byte_done;
    input [4:0] count;
    begin
      byte_done = (count == `SFPE_BYTE_LAST);
    end
  endfunction

  reg  [2:0]              cs_q;
  reg  [2:0]              sck_q;
  reg  [1:0]              si_q;
  reg  [5:0]              state_r;
  reg  [4:0]              cnt_r;
  reg  [7:0]              sr_r;
  reg  [7:0]              op_r;
  reg  [`SFPE_ADDR_W-1:0] addr_r;
  reg  [1:0]              omode_r;
  reg  [2:0]              obit_r;
  reg  [7:0]              obyte_r;
  reg                     so_r;
  reg                     oe_r;
  reg                     arm_r;
  reg                     busy_r;
  reg                     latch_r;
  reg  [31:0]             timer_r;
  reg                     walk_r;
  reg  [7:0]              walk_idx_r;
  reg  [7:0]              pg_data_r [0:`SFPE_PAGE_BYTES-1];
  reg  [`SFPE_PAGE_BYTES-1:0] pg_valid_r;
  reg  [`SFPE_ADDR_W-1:0] mem_addr_r;
  reg                     mem_wr_r;
  reg  [7:0]              mem_wdata_r;
  reg                     er_sect_r;
  reg                     er_all_r;

  wire       sck_rise = sck_q[1] & ~sck_q[2];
  wire       sck_fall = ~sck_q[1] & sck_q[2];
  wire       cs_hi    = cs_q[1];
  wire       cs_rise  = cs_q[1] & ~cs_q[2];
  wire       si_bit   = si_q[1];
  wire [7:0] sr_nxt   = {sr_r[6:0], si_bit};
  wire [7:0] status_byte = {3'h0, I_PROTECT_LEVEL, latch_r, busy_r};
  wire [6:0] sector   = addr_r[`SFPE_ADDR_W-1:`SFPE_SECTOR_LSB];
  wire [7:0] pg_off   = addr_r[`SFPE_PAGE_LSB-1:0];
  wire       wr_block = busy_r | ~latch_r;

  // Two-flop synchronisers for the link pins
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cs_q  <= 3'h7;
      sck_q <= 3'h0;
      si_q  <= 2'h0;
    end else begin
      cs_q  <= {cs_q[1:0], I_CS_N};
      sck_q <= {sck_q[1:0], I_SCK};
      si_q  <= {si_q[0], I_SI};
    end
  end

  // Page buffer; later bytes overwrite earlier ones at the same offset
  always @(posedge I_CLK) begin
    if (state_r == ST_PDATA && sck_rise && !cs_hi && byte_done(cnt_r)) begin
      pg_data_r[pg_off] <= sr_nxt;
    end
  end

  // Serial instruction decoder
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r    <= ST_CMD;
      cnt_r      <= 5'h00;
      sr_r       <= 8'h00;
      op_r       <= 8'h00;
      addr_r     <= {`SFPE_ADDR_W{1'b0}};
      omode_r    <= OM_MEM;
      obit_r     <= 3'h0;
      obyte_r    <= 8'h00;
      so_r       <= 1'b0;
      oe_r       <= 1'b0;
      arm_r      <= 1'b0;
      pg_valid_r <= {`SFPE_PAGE_BYTES{1'b0}};
    end else if (cs_hi) begin
      state_r <= ST_CMD;
      cnt_r   <= 5'h00;
      obit_r  <= 3'h0;
      oe_r    <= 1'b0;
      arm_r   <= 1'b0;
    end else if (sck_rise) begin
      case (state_r)
        ST_CMD: begin
          sr_r  <= sr_nxt;
          cnt_r <= cnt_r + 5'h01;
          if (byte_done(cnt_r)) begin
            op_r  <= sr_nxt;
            cnt_r <= 5'h00;
            state_r <= ST_SKIP;
            if (sr_nxt == P_OP_QUICK_READ && !busy_r) begin
              state_r <= ST_ADDR;
              omode_r <= OM_MEM;
            end else if ((sr_nxt == P_OP_PAGE_WRITE || sr_nxt == P_OP_BLOCK_WIPE)
                         && !wr_block) begin
              state_r <= ST_ADDR;
            end else if (sr_nxt == P_OP_FULL_WIPE && !wr_block) begin
              arm_r <= 1'b1;
            end else if (sr_nxt == P_OP_LEGACY_ID) begin
              state_r <= ST_DUMMY;
              omode_r <= OM_SIG;
            end else if (sr_nxt == P_OP_STATUS_READ) begin
              state_r <= ST_OUT;
              omode_r <= OM_STAT;
            end
          end
        end
        ST_ADDR: begin
          // A23 falls off the top of the shift
          addr_r <= {addr_r[`SFPE_ADDR_W-2:0], si_bit};
          cnt_r  <= cnt_r + 5'h01;
          if (cnt_r == `SFPE_ADDR_LAST) begin
            cnt_r <= 5'h00;
            if (op_r == P_OP_QUICK_READ) begin
              state_r <= ST_DUMMY;
            end else if (op_r == P_OP_PAGE_WRITE) begin
              state_r    <= ST_PDATA;
              pg_valid_r <= {`SFPE_PAGE_BYTES{1'b0}};
            end else begin
              state_r <= ST_SKIP;
              arm_r   <= 1'b1;
            end
          end
        end
        ST_DUMMY: begin
          cnt_r <= cnt_r + 5'h01;
          if ((op_r == P_OP_QUICK_READ && cnt_r == `SFPE_BYTE_LAST) ||
              (op_r != P_OP_QUICK_READ && cnt_r == `SFPE_SIG_DUMMY_LAST)) begin
            cnt_r   <= 5'h00;
            state_r <= ST_OUT;
          end
        end
        ST_PDATA: begin
          sr_r  <= sr_nxt;
          cnt_r <= cnt_r + 5'h01;
          arm_r <= 1'b0;
          if (byte_done(cnt_r)) begin
            cnt_r <= 5'h00;
            arm_r <= 1'b1;
            pg_valid_r[pg_off] <= 1'b1;
            addr_r[`SFPE_PAGE_LSB-1:0] <= pg_off + 8'h01;
          end
        end
        ST_SKIP: begin
          arm_r <= 1'b0;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end else if (sck_fall && state_r == ST_OUT) begin
      oe_r   <= 1'b1;
      obit_r <= obit_r + 3'h1;
      if (obit_r == 3'h0) begin
        case (omode_r)
          OM_MEM:  begin obyte_r <= {I_MEM_RDATA[6:0], 1'b0}; so_r <= I_MEM_RDATA[7]; end
          OM_SIG:  begin obyte_r <= {P_SIGNATURE[6:0], 1'b0}; so_r <= P_SIGNATURE[7]; end
          default: begin obyte_r <= {status_byte[6:0], 1'b0}; so_r <= status_byte[7]; end
        endcase
      end else begin
        obyte_r <= {obyte_r[6:0], 1'b0};
        so_r    <= obyte_r[7];
      end
      if (obit_r == 3'h7 && omode_r == OM_MEM) begin
        addr_r <= addr_r + {{(`SFPE_ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Self-timed program and erase engine
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      busy_r      <= 1'b0;
      latch_r     <= 1'b0;
      timer_r     <= 32'h0;
      walk_r      <= 1'b0;
      walk_idx_r  <= 8'h00;
      mem_addr_r  <= {`SFPE_ADDR_W{1'b0}};
      mem_wr_r    <= 1'b0;
      mem_wdata_r <= 8'h00;
      er_sect_r   <= 1'b0;
      er_all_r    <= 1'b0;
    end else begin
      mem_wr_r  <= 1'b0;
      er_sect_r <= 1'b0;
      er_all_r  <= 1'b0;
      // Unlock takes effect at opcode decode, before deselect
      if (!cs_hi && sck_rise && state_r == ST_CMD && byte_done(cnt_r) &&
          sr_nxt == P_OP_WRITE_UNLOCK) begin
        latch_r <= 1'b1;
      end
      // Timer holds length minus one, so busy stands for the full length
      if (busy_r) begin
        timer_r <= timer_r - 32'h1;
        if (timer_r == 32'h0) begin
          busy_r <= 1'b0;
        end
      end else if (cs_rise && arm_r) begin
        if (op_r == P_OP_PAGE_WRITE && !prot_hit(I_PROTECT_LEVEL, sector)) begin
          busy_r     <= 1'b1;
          latch_r    <= 1'b0;
          timer_r    <= P_PAGE_WRITE_CYC - 32'h1;
          walk_r     <= 1'b1;
          walk_idx_r <= 8'h00;
        end else if (op_r == P_OP_BLOCK_WIPE && !prot_hit(I_PROTECT_LEVEL, sector)) begin
          busy_r     <= 1'b1;
          latch_r    <= 1'b0;
          timer_r    <= P_BLOCK_WIPE_CYC - 32'h1;
          er_sect_r  <= 1'b1;
          mem_addr_r <= addr_r;
        end else if (op_r == P_OP_FULL_WIPE && I_PROTECT_LEVEL == 3'h0) begin
          busy_r     <= 1'b1;
          latch_r    <= 1'b0;
          timer_r    <= P_FULL_WIPE_CYC - 32'h1;
          er_all_r   <= 1'b1;
        end
      end
      if (walk_r) begin
        // Array clears bits only; untouched offsets keep their data
        mem_wr_r    <= pg_valid_r[walk_idx_r];
        mem_wdata_r <= pg_data_r[walk_idx_r];
        mem_addr_r  <= {addr_r[`SFPE_ADDR_W-1:`SFPE_PAGE_LSB], walk_idx_r};
        walk_idx_r  <= walk_idx_r + 8'h01;
        if (walk_idx_r == 8'hFF) begin
          walk_r <= 1'b0;
        end
      end else if (!busy_r && !(cs_rise && arm_r)) begin
        mem_addr_r <= addr_r;
      end
    end
  end

  assign O_SO             = so_r;
  assign O_SO_OE_N        = ~oe_r;
  assign O_BUSY           = busy_r;
  assign O_WRITE_LATCH    = latch_r;
  assign O_MEM_ADDR       = mem_addr_r;
  assign O_MEM_WR         = mem_wr_r;
  assign O_MEM_WDATA      = mem_wdata_r;
  assign O_MEM_ERASE_SECT = er_sect_r;
  assign O_MEM_ERASE_ALL  = er_all_r;

endmodule // sfpe_flash_seq
`default_nettype wire

// ===== verif/sfpe_flash_seq_props.sv
`timescale 1ns/10ps
`default_nettype none
module sfpe_flash_seq_props #(
  parameter [31:0] P_PAGE_WRITE_CYC = 32'd400,
  parameter [31:0] P_BLOCK_WIPE_CYC = 32'd300,
  parameter [31:0] P_FULL_WIPE_CYC  = 32'd500
) (
  // Clock and reset
  input wire logic       I_CLK,
  input wire logic       I_RESET_N,
  // Serial link
  input wire logic       I_CS_N,
  input wire logic       I_SCK,
  input wire logic       O_SO,
  input wire logic       O_SO_OE_N,
  // Status and array
  input wire logic [2:0] I_PROTECT_LEVEL,
  input wire logic       O_BUSY,
  input wire logic       O_WRITE_LATCH,
  input wire logic       O_MEM_WR,
  input wire logic       O_MEM_ERASE_SECT,
  input wire logic       O_MEM_ERASE_ALL
);
  logic [31:0] busy_cnt_r;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) busy_cnt_r <= 32'h0;
    else busy_cnt_r <= O_BUSY ? busy_cnt_r + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_oe_release: assert property (I_CS_N [*5] |-> O_SO_OE_N)
    else $error("output still driven after deselect");
  a_latch_off: assert property ($rose(O_BUSY) |-> ##[0:2] !O_WRITE_LATCH)
    else $error("write latch not cleared in cycle");
  a_latch_need: assert property ($rose(O_BUSY) |-> $past(O_WRITE_LATCH, 2))
    else $error("cycle started without write latch");
  a_busy_start: assert property ($rose(O_BUSY) |-> I_CS_N && $past(I_CS_N))
    else $error("cycle started while selected");
  a_mem_busy: assert property ((O_MEM_WR || O_MEM_ERASE_SECT || O_MEM_ERASE_ALL) |-> O_BUSY)
    else $error("array change outside a busy cycle");
  a_erase_all: assert property (O_MEM_ERASE_ALL |-> $past(I_PROTECT_LEVEL) == 3'h0)
    else $error("full erase with protection set");
  a_sect_prot: assert property (O_MEM_ERASE_SECT |-> $past(I_PROTECT_LEVEL) != 3'h7)
    else $error("sector erase in protected area");
  a_so_edge: assert property (!O_SO_OE_N && $changed(O_SO) |-> !I_SCK)
    else $error("output bit changed while clock high");
  a_busy_len: assert property ($fell(O_BUSY) |-> busy_cnt_r == P_PAGE_WRITE_CYC
    || busy_cnt_r == P_BLOCK_WIPE_CYC || busy_cnt_r == P_FULL_WIPE_CYC)
    else $error("busy length wrong");
endmodule // sfpe_flash_seq_props
bind sfpe_flash_seq sfpe_flash_seq_props #(
  .P_PAGE_WRITE_CYC(P_PAGE_WRITE_CYC),
  .P_BLOCK_WIPE_CYC(P_BLOCK_WIPE_CYC),
  .P_FULL_WIPE_CYC (P_FULL_WIPE_CYC)
) u_props (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CS_N(I_CS_N), .I_SCK(I_SCK),
  .O_SO(O_SO), .O_SO_OE_N(O_SO_OE_N), .I_PROTECT_LEVEL(I_PROTECT_LEVEL),
  .O_BUSY(O_BUSY), .O_WRITE_LATCH(O_WRITE_LATCH), .O_MEM_WR(O_MEM_WR),
  .O_MEM_ERASE_SECT(O_MEM_ERASE_SECT), .O_MEM_ERASE_ALL(O_MEM_ERASE_ALL)
);
`default_nettype wire

// ===== verif/sfpe_spi_master.sv
`timescale 1ns/10ps
`default_nettype none
module sfpe_spi_master (
  // Link to device
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n,
  // Frame status
  output logic      drove
);
  logic so_last;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    drove = 1'b0;
    so_last = 1'b0;
  end
  // Quarter-ns offset keeps link edges clear of the clock edges
  task automatic start();
    #40.25 cs_n = 1'b0;
    drove = 1'b0;
    #32;
  endtask
  // Mode 0, released line reads as inverse of last bit
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      #32 sck = 1'b1;
      rx[i] = so_oe_n ? ~so_last : so;
      so_last = rx[i];
      drove = drove | ~so_oe_n;
      #32 sck = 1'b0;
    end
  endtask
  task automatic stop();
    #16 cs_n = 1'b1;
    si = ~si;
    #63.75;
  endtask
endmodule // sfpe_spi_master
`default_nettype wire

// ===== verif/sfpe_flash_seq_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sfpe_flash_seq_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  prot = 3'h5;
  logic [7:0]  mem_rdata = 8'hFF;
  wire         cs_n, sck, si, so, so_oe_n, busy, latch, mem_wr, er_s, er_a, drove;
  wire  [22:0] mem_addr;
  wire  [7:0]  mem_wdata;
  logic [7:0]  mem [int];
  logic [7:0]  rx0, rx1;
  logic [7:0]  q [$];
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [39:0] t_b [4] = '{40'hAB00000000, 40'h0500000000, 40'h0B80001000, 40'h0B7FFFFF00};
  int          t_n [4] = '{4, 1, 5, 5};
  logic [15:0] t_e [4] = '{16'h5A5A, 16'h1414, 16'hA53C, 16'h8142};
  always #2.5 clk = ~clk;
  sfpe_flash_seq #(.P_PAGE_WRITE_CYC(32'd4000), .P_BLOCK_WIPE_CYC(32'd3000),
    .P_FULL_WIPE_CYC(32'd5000)) dut (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_CS_N(cs_n), .I_SCK(sck), .I_SI(si), .O_SO(so),
    .O_SO_OE_N(so_oe_n), .I_PROTECT_LEVEL(prot), .O_BUSY(busy), .O_WRITE_LATCH(latch),
    .O_MEM_ADDR(mem_addr), .I_MEM_RDATA(mem_rdata), .O_MEM_WR(mem_wr),
    .O_MEM_WDATA(mem_wdata), .O_MEM_ERASE_SECT(er_s), .O_MEM_ERASE_ALL(er_a));
  sfpe_spi_master u_m (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n),
    .drove(drove));
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // Array model: clear-only writes, erase to ones
  always @(negedge clk) mem_rdata <= rd(mem_addr);
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] = rd(mem_addr) & mem_wdata;
    if (er_a) mem.delete();
    if (er_s) for (int a = 0; a < 65536; a++) mem.delete(int'({mem_addr[22:16], a[15:0]}));
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic frame(input logic [7:0] b [$], input int nout, input int tail);
    logic [7:0] r;
    u_m.start();
    foreach (b[k]) u_m.xfer(b[k], 8, r);
    if (tail > 0) u_m.xfer(8'hFF, tail, r);
    if (nout > 0) u_m.xfer(8'hFF, 8, rx0);
    if (nout > 1) u_m.xfer(8'hFF, 8, rx1);
    u_m.stop();
  endtask
  task automatic wait_idle();
    repeat (6000) if (busy !== 1'b0) @(posedge clk);
    check("busy_end", 8'(busy), 8'h00);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    mem[32'h10] = 8'hA5;
    mem[32'h11] = 8'h3C;
    mem[32'h7FFFFF] = 8'h81;
    mem[32'h0] = 8'h42;
    repeat (10) @(posedge clk);
    check("rst_busy", 8'(busy), 8'h00);
    check("rst_latch", 8'(latch), 8'h00);
    check("rst_oe_n", 8'(so_oe_n), 8'h01);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      q = {};
      for (int k = 0; k < t_n[i]; k++) q.push_back(t_b[i][39 - 8 * k -: 8]);
      frame(q, 2, 0);
      check("row_out0", rx0, t_e[i][15:8]);
      check("row_out1", rx1, t_e[i][7:0]);
      check("row_oe_n", 8'(so_oe_n), 8'h01);
    end
    frame('{8'hAB, 8'h00, 8'h00, 8'h00}, 0, 3);
    frame('{8'h05}, 1, 0);
    check("standby", rx0, 8'h14);
    @(posedge clk) #1 prot = 3'h0;
    frame('{8'h02, 8'h00, 8'h00, 8'hFE, 8'h0F}, 0, 0);
    check("no_latch", 8'(busy), 8'h00);
    frame('{8'h06}, 0, 0);
    check("latch_set", 8'(latch), 8'h01);
    frame('{8'h02, 8'h00, 8'h00, 8'hFE, 8'h0F, 8'hF0, 8'h33}, 0, 0);
    check("pw_busy", 8'(busy), 8'h01);
    check("pw_latch", 8'(latch), 8'h00);
    frame('{8'h0B, 8'h00, 8'h00, 8'h10, 8'h00}, 2, 0);
    check("rd_reject", 8'(drove), 8'h00);
    frame('{8'h05}, 1, 0);
    check("poll", rx0, 8'h01);
    frame('{8'h06}, 0, 0);
    frame('{8'hD8, 8'h7F, 8'hFF, 8'hFF}, 0, 0);
    wait_idle();
    check("busy_wipe", rd(32'h7FFFFF), 8'h81);
    check("pw_fe", rd(32'hFE), 8'h0F);
    check("pw_ff", rd(32'hFF), 8'hF0);
    check("pw_wrap", rd(32'h0), 8'h02);
    check("pw_rest", rd(32'h1), 8'hFF);
    frame('{8'h06}, 0, 0);
    frame('{8'h02, 8'h00, 8'h01, 8'h00, 8'h55}, 0, 4);
    check("pw_cut", 8'(busy), 8'h00);
    @(posedge clk) #1 prot = 3'h7;
    frame('{8'hD8, 8'h00, 8'h00, 8'h10}, 0, 0);
    check("bw_prot", 8'(busy), 8'h00);
    @(posedge clk) #1 prot = 3'h0;
    frame('{8'hD8, 8'h00, 8'h00, 8'h10}, 0, 3);
    check("bw_cut", 8'(busy), 8'h00);
    frame('{8'hD8, 8'h00, 8'h00, 8'h20}, 0, 0);
    check("bw_busy", 8'(busy), 8'h01);
    wait_idle();
    check("bw_ones", rd(32'h10), 8'hFF);
    check("bw_other", rd(32'h7FFFFF), 8'h81);
    frame('{8'h06}, 0, 0);
    @(posedge clk) #1 prot = 3'h1;
    frame('{8'hC7}, 0, 0);
    check("fw_prot", 8'(busy), 8'h00);
    @(posedge clk) #1 prot = 3'h0;
    frame('{8'hC7}, 0, 1);
    check("fw_cut", 8'(busy), 8'h00);
    frame('{8'hC7}, 0, 0);
    check("fw_busy", 8'(busy), 8'h01);
    wait_idle();
    check("fw_ones", rd(32'h7FFFFF), 8'hFF);
    frame('{8'h06}, 0, 0);
    q = '{8'h02, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 258; k++) q.push_back(k > 255 ? 8'hFF : 8'h00);
    frame(q, 0, 0);
    wait_idle();
    check("pw_last0", rd(32'h0), 8'hFF);
    check("pw_last2", rd(32'h2), 8'h00);
    report_and_stop();
  end
endmodule // sfpe_flash_seq_tb
`default_nettype wire
